// ==== shared/iacd_pkg.sv ====
// Constants and types for the integer arithmetic and class decode block.
package iacd_pkg;

  // ****************************************************************
  // Register offsets on the APB slave.
  // ****************************************************************
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_SRC_A = 8'h04;
  localparam logic [7:0] OFF_SRC_B = 8'h08;
  localparam logic [7:0] OFF_XER = 8'h0C;
  localparam logic [7:0] OFF_RESULT = 8'h10;
  localparam logic [7:0] OFF_COND = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_VECTOR = 8'h1C;

  // ****************************************************************
  // Field positions and reset values.
  // ****************************************************************
  localparam int XER_SO_BIT = 31;
  localparam int XER_OV_BIT = 30;
  localparam int XER_CA_BIT = 29;
  localparam int STAT_EMU_BIT = 2;
  localparam int STAT_EXEC_BIT = 3;
  localparam int STAT_DELEG_BIT = 4;
  localparam int OE_BIT = 10;
  localparam int REC_BIT = 0;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [3:0] RST_COND = 4'h0;
  localparam logic [31:0] EMU_VECTOR = 32'h0000_1000;

  // ****************************************************************
  // Primary opcodes used by the class decoder and extended opcodes of the add and subtract group.
  // ****************************************************************
  localparam logic [5:0] OP_SUBFIC = 6'h08;
  localparam logic [5:0] OP_ADDIC = 6'h0C;
  localparam logic [5:0] OP_ADDIC_REC = 6'h0D;
  localparam logic [5:0] OP_ADDI = 6'h0E;
  localparam logic [5:0] OP_ADDIS = 6'h0F;
  localparam logic [5:0] OP_EXT19 = 6'h13;
  localparam logic [5:0] OP_EXT31 = 6'h1F;
  localparam logic [5:0] OP_EXT59 = 6'h3B;
  localparam logic [5:0] OP_EXT63 = 6'h3F;
  localparam logic [5:0] OP_ROT64 = 6'h1E;
  localparam logic [5:0] OP_RSVD = 6'h05;
  localparam logic [8:0] XO_ADD = 9'h10A;
  localparam logic [8:0] XO_ADDC = 9'h00A;
  localparam logic [8:0] XO_SUBF = 9'h028;
  localparam logic [8:0] XO_SUBFC = 9'h008;
  localparam logic [8:0] XO_ADDE = 9'h08A;
  localparam logic [8:0] XO_SUBFE = 9'h088;
  localparam logic [8:0] XO_ADDME = 9'h0EA;
  localparam logic [8:0] XO_SUBFME = 9'h0E8;
  localparam logic [8:0] XO_ADDZE = 9'h0CA;
  localparam logic [8:0] XO_SUBFZE = 9'h0C8;
  localparam logic [8:0] XO_NEG = 9'h068;

  // Instruction class, Gray coded along defined, illegal, reserved.
  typedef enum logic [1:0] {
    CLS_DEFINED = 2'h0,
    CLS_ILLEGAL = 2'h1,
    CLS_RESERVED = 2'h3
  } iacd_cls_type;

endpackage : iacd_pkg

// ==== hdl/iacd_core.sv ====
// Instruction class decoder and integer add/subtract unit behind APB.
//
// Overview of operation
// - Class from primary plus extended opcode.
// - Sixty-four-bit-only encodings decode as illegal.
// - Listed user, environment, optional instructions are defined.
// - Invalid defined forms trap to emulation.
// - Trapped instruction leaves machine state unchanged.
// - Reserved bits set behave as if zero, except a nonzero second field in minus-one, zero and negate forms, which traps.
// - Unimplemented defined instructions set the delegate status flag, no trap.
// - Every illegal encoding invokes emulation handler.
// - All-zero instruction word is always illegal.
// - Unimplemented reserved instruction takes emulation exception.
// - Operands from registers, results to registers, flags.
// - Record forms set condition field by sign.
// - Carrying forms write carry out of bit 0.
// - Overflow enable sets overflow and sticky summary.
// - Flags derive from value written to destination.
// - Dot records, o enables overflow, both combine.
// - add and addc write sum of sources.
// - subf writes complement of first plus second plus one.
// - addic adds signed immediate; dot form records.
// - subfic complements source, adds immediate plus one.
`timescale 1ns/10ps

module iacd_core
  import iacd_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave request.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  // APB slave answer.
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Software emulation exception request to the exception unit.
  output logic emu_exc
);

  // ****************************************************************
  // Decode functions.
  // ****************************************************************

  // Classifies the full instruction word.
  function automatic iacd_cls_type classify(input logic [31:0] w);
    logic [9:0] xo10;
    logic [8:0] xo9;
    logic [4:0] xo5;
    iacd_cls_type c;
    xo10 = w[10:1];
    xo9 = w[9:1];
    xo5 = w[5:1];
    c = CLS_ILLEGAL;
    case (w[31:26])
      6'h03, 6'h07, 6'h08, 6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h0F,
      6'h10, 6'h11, 6'h12, 6'h14, 6'h15, 6'h17, 6'h18, 6'h19, 6'h1A,
      6'h1B, 6'h1C, 6'h1D: begin
        c = CLS_DEFINED;
      end
      OP_EXT19: begin
        case (xo10)
          10'h000, 10'h010, 10'h032, 10'h021, 10'h081, 10'h096,
          10'h0C1, 10'h0E1, 10'h101, 10'h121, 10'h1A1, 10'h1C1,
          10'h210: c = CLS_DEFINED;
          default: c = CLS_ILLEGAL;
        endcase
      end
      OP_EXT31: begin
        case (xo9)
          XO_ADD, XO_ADDC, XO_SUBF, XO_SUBFC, XO_ADDE, XO_SUBFE,
          XO_ADDME, XO_SUBFME, XO_ADDZE, XO_SUBFZE, XO_NEG,
          9'h0EB, 9'h04B, 9'h00B, 9'h1EB, 9'h1CB: c = CLS_DEFINED;
          default: c = CLS_ILLEGAL;
        endcase
        case (xo10)
          10'h000, 10'h020, 10'h01C, 10'h03C, 10'h1BC, 10'h07C,
          10'h13C, 10'h11C, 10'h1DC, 10'h19C, 10'h018, 10'h218,
          10'h318, 10'h338, 10'h01A, 10'h39A, 10'h3BA, 10'h153,
          10'h1D3, 10'h053, 10'h092, 10'h013, 10'h090, 10'h173,
          10'h356, 10'h3D6, 10'h256, 10'h3D7, 10'h017, 10'h097,
          10'h057, 10'h0D7, 10'h117, 10'h197, 10'h004, 10'h200,
          10'h014, 10'h096, 10'h217, 10'h257, 10'h297, 10'h2D7,
          10'h056, 10'h036, 10'h116, 10'h3F6: c = CLS_DEFINED;
          default: c = c;
        endcase
      end
      OP_EXT59: begin
        case (xo5)
          5'h12, 5'h14, 5'h15, 5'h19, 5'h1C, 5'h1D, 5'h1E,
          5'h1F: c = CLS_DEFINED;
          default: c = CLS_ILLEGAL;
        endcase
      end
      OP_EXT63: begin
        case (xo5)
          5'h12, 5'h14, 5'h15, 5'h17, 5'h19, 5'h1C, 5'h1D, 5'h1E,
          5'h1F: c = CLS_DEFINED;
          default: c = CLS_ILLEGAL;
        endcase
        case (xo10)
          10'h000, 10'h00C, 10'h00E, 10'h00F, 10'h020, 10'h026,
          10'h028, 10'h040, 10'h046, 10'h048, 10'h088, 10'h108,
          10'h247, 10'h2C7: c = CLS_DEFINED;
          default: c = c;
        endcase
      end
      OP_RSVD: begin
        c = CLS_RESERVED;
      end
      default: begin
        c = (w[31:26] >= 6'h20 && w[31:26] <= 6'h37) ?
            CLS_DEFINED : CLS_ILLEGAL;
      end
    endcase
    return c;
  endfunction : classify

  // Selects the APB offset group that this slave answers.
  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= OFF_VECTOR);
  endfunction : mapped

  // ****************************************************************
  // Registers.
  // ****************************************************************
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic emu_exc_ff;
  logic [31:0] instr_ff;
  logic [31:0] src_a_ff;
  logic [31:0] src_b_ff;
  logic so_ff;
  logic ov_ff;
  logic ca_ff;
  logic [31:0] result_ff;
  logic [3:0] cond_ff;
  iacd_cls_type cls_ff;
  logic emu_seen_ff;
  logic exec_ff;
  logic deleg_ff;

  // ****************************************************************
  // Bus strobes and the instruction datapath.
  // ****************************************************************
  logic acc_wr;
  logic wr_instr;
  logic [31:0] nxt_rdata;
  logic arith;
  logic bad_form;
  logic wr_ca;
  logic ov_en;
  logic rec;
  logic [31:0] a_in;
  logic [31:0] b_in;
  logic c_in;
  logic [31:0] signed_immediate_ext;
  logic [32:0] sum33;
  logic sum_ov;
  logic nxt_so;
  logic [3:0] nxt_cond;
  iacd_cls_type nxt_cls;
  logic trap;
  logic commit;

  // A write takes effect at the access edge where pready is high.
  assign acc_wr = psel & penable & pwrite & pready_ff;
  assign wr_instr = acc_wr & (paddr == OFF_INSTR);

  // The written word is decoded and executed in the same edge.
  // class decode
  assign nxt_cls = classify(pwdata);

  // Operand selection for the add and subtract group.
  always_comb begin
    arith = 1'b0;
    bad_form = 1'b0;
    wr_ca = 1'b0;
    ov_en = 1'b0;
    rec = 1'b0;
    c_in = 1'b0;
    a_in = src_a_ff;
    b_in = src_b_ff;
    signed_immediate_ext = {{16{pwdata[15]}}, pwdata[15:0]};
    case (pwdata[31:26])
      OP_ADDI: begin
        arith = 1'b1;
        a_in = (pwdata[20:16] == 5'h00) ? RST_WORD : src_a_ff;
        b_in = signed_immediate_ext;
      end
      OP_ADDIS: begin
        arith = 1'b1;
        a_in = (pwdata[20:16] == 5'h00) ? RST_WORD : src_a_ff;
        b_in = {pwdata[15:0], 16'h0000};
      end
      OP_ADDIC, OP_ADDIC_REC: begin
        arith = 1'b1;
        b_in = signed_immediate_ext;
        wr_ca = 1'b1;
        rec = (pwdata[31:26] == OP_ADDIC_REC);
      end
      OP_SUBFIC: begin
        arith = 1'b1;
        a_in = ~src_a_ff;
        b_in = signed_immediate_ext;
        c_in = 1'b1;
        wr_ca = 1'b1;
      end
      OP_EXT31: begin
        ov_en = pwdata[OE_BIT];
        rec = pwdata[REC_BIT];
        arith = 1'b1;
        case (pwdata[9:1])
          XO_ADD: b_in = src_b_ff;
          XO_ADDC: wr_ca = 1'b1;
          XO_SUBF: begin
            a_in = ~src_a_ff;
            c_in = 1'b1;
          end
          XO_SUBFC: begin
            a_in = ~src_a_ff;
            c_in = 1'b1;
            wr_ca = 1'b1;
          end
          XO_ADDE: begin
            c_in = ca_ff;
            wr_ca = 1'b1;
          end
          XO_SUBFE: begin
            a_in = ~src_a_ff;
            c_in = ca_ff;
            wr_ca = 1'b1;
          end
          XO_ADDME, XO_SUBFME, XO_ADDZE, XO_SUBFZE: begin
            a_in = pwdata[2] ? src_a_ff : ~src_a_ff;
            b_in = pwdata[6] ? 32'hFFFF_FFFF : 32'h0000_0000;
            c_in = ca_ff;
            wr_ca = 1'b1;
            bad_form = (pwdata[15:11] != 5'h00);
          end
          XO_NEG: begin
            a_in = ~src_a_ff;
            b_in = 32'h0000_0000;
            c_in = 1'b1;
            bad_form = (pwdata[15:11] != 5'h00);
          end
          default: begin
            arith = 1'b0;
            ov_en = 1'b0;
            rec = 1'b0;
          end
        endcase
      end
      default: begin
        arith = 1'b0;
      end
    endcase
  end

  assign sum33 = {1'b0, a_in} + {1'b0, b_in} + {32'h0000_0000, c_in};
  assign sum_ov = (a_in[31] == b_in[31]) & (sum33[31] != a_in[31]);
  assign nxt_so = so_ff | (ov_en & sum_ov);
  assign nxt_cond = {sum33[31], ~sum33[31] & (|sum33[31:0]),
                     sum33[31:0] == RST_WORD, nxt_so};

  assign trap = wr_instr & ((nxt_cls != CLS_DEFINED) | bad_form);
  assign commit = wr_instr & (nxt_cls == CLS_DEFINED) & arith &
                  ~bad_form;

  // ****************************************************************
  // APB slave response.
  // ****************************************************************

  // Read data multiplexer; unmapped offsets read zero.
  always_comb begin
    nxt_rdata = RST_WORD;
    case (paddr)
      OFF_INSTR: nxt_rdata = instr_ff;
      OFF_SRC_A: nxt_rdata = src_a_ff;
      OFF_SRC_B: nxt_rdata = src_b_ff;
      OFF_XER: begin
        nxt_rdata[XER_SO_BIT] = so_ff;
        nxt_rdata[XER_OV_BIT] = ov_ff;
        nxt_rdata[XER_CA_BIT] = ca_ff;
      end
      OFF_RESULT: nxt_rdata = result_ff;
      OFF_COND: nxt_rdata[3:0] = cond_ff;
      OFF_STATUS: begin
        nxt_rdata[1:0] = cls_ff;
        nxt_rdata[STAT_EMU_BIT] = emu_seen_ff;
        nxt_rdata[STAT_EXEC_BIT] = exec_ff;
        nxt_rdata[STAT_DELEG_BIT] = deleg_ff;
      end
      OFF_VECTOR: nxt_rdata = EMU_VECTOR;
      default: nxt_rdata = RST_WORD;
    endcase
  end

  // Answers in the first access cycle; data is captured in setup.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= RST_WORD;
    end else begin
      pready_ff <= psel & ~penable;
      pslverr_ff <= psel & ~penable & ~mapped(paddr);
      if (psel & ~penable & ~pwrite) begin
        prdata_ff <= nxt_rdata;
      end
    end
  end

  // Software-written instruction word and operand registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_ff <= RST_WORD;
      src_a_ff <= RST_WORD;
      src_b_ff <= RST_WORD;
    end else begin
      if (wr_instr) begin
        instr_ff <= pwdata;
      end
      if (acc_wr & (paddr == OFF_SRC_A)) begin
        src_a_ff <= pwdata;
      end
      if (acc_wr & (paddr == OFF_SRC_B)) begin
        src_b_ff <= pwdata;
      end
    end
  end

  // Exception register flags; execution and software writes never
  // share an edge, as each needs its own APB transfer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      so_ff <= 1'b0;
      ov_ff <= 1'b0;
      ca_ff <= 1'b0;
    end else if (acc_wr & (paddr == OFF_XER)) begin
      so_ff <= pwdata[XER_SO_BIT];
      ov_ff <= pwdata[XER_OV_BIT];
      ca_ff <= pwdata[XER_CA_BIT];
    end else if (commit) begin
      if (wr_ca) begin
        ca_ff <= sum33[32];
      end
      if (ov_en) begin
        ov_ff <= sum_ov;
        so_ff <= nxt_so;
      end
    end
  end

  // Destination value and condition field.
  // trap leaves state untouched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_ff <= RST_WORD;
      cond_ff <= RST_COND;
    end else if (commit) begin
      result_ff <= sum33[31:0];
      if (rec) begin
        cond_ff <= nxt_cond;
      end
    end
  end

  // Class, exception request and status flags.
  // illegal words trap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cls_ff <= CLS_DEFINED;
      emu_exc_ff <= 1'b0;
      emu_seen_ff <= 1'b0;
      exec_ff <= 1'b0;
      deleg_ff <= 1'b0;
    end else begin
      emu_exc_ff <= trap;
      if (wr_instr) begin
        cls_ff <= nxt_cls;
        emu_seen_ff <= trap;
        exec_ff <= commit;
        deleg_ff <= ~trap & ~commit;
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign emu_exc = emu_exc_ff;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_take(logic [31:0] word);
    wr_instr && pwdata == word;
  endsequence

  sequence s_trapped;
    emu_exc_ff && emu_seen_ff && !exec_ff;
  endsequence

  chk_zero_word_illegal: assert property (
    s_take(32'h0000_0000) |=> s_trapped ##0 cls_ff == CLS_ILLEGAL)
    else $error("zero word not trapped as illegal");

  chk_illegal_traps: assert property (
    wr_instr && nxt_cls == CLS_ILLEGAL |=> s_trapped ##1 !emu_exc_ff)
    else $error("illegal word missed the emulation request");

  chk_wide_op_illegal: assert property (
    wr_instr && pwdata[31:26] == OP_ROT64 |=> cls_ff == CLS_ILLEGAL)
    else $error("64-bit rotate not illegal");

  chk_reserved_traps: assert property (
    wr_instr && pwdata[31:26] == OP_RSVD |=> s_trapped)
    else $error("reserved word not trapped");

  chk_trap_keeps_state: assert property (
    trap |=> $stable(result_ff) && $stable(cond_ff) && $stable(ca_ff))
    else $error("trapped word changed state");

  chk_add_sum_value: assert property (
    wr_instr && pwdata[31:26] == OP_EXT31 && pwdata[9:1] == XO_ADD
    |=> result_ff == $past(src_a_ff) + $past(src_b_ff))
    else $error("add result wrong");

  chk_subf_diff_value: assert property (
    commit && pwdata[31:26] == OP_EXT31 && pwdata[9:1] == XO_SUBF
    |=> result_ff == $past(src_b_ff) - $past(src_a_ff))
    else $error("subf result wrong");

  chk_cond_sign_eq: assert property (
    commit && rec |=> cond_ff[3] == result_ff[31] &&
    cond_ff[1] == (result_ff == RST_WORD) && cond_ff[0] == so_ff)
    else $error("condition field does not match result");

  chk_so_sticky: assert property (
    so_ff && !(acc_wr && paddr == OFF_XER) |=> so_ff)
    else $error("summary overflow cleared by hardware");

  chk_subfic_carry: assert property (
    commit && pwdata[31:26] == OP_SUBFIC |=>
    ca_ff == ($past(signed_immediate_ext) >= $past(src_a_ff)))
    else $error("subfic carry not the no-borrow flag");

endmodule : iacd_core

// ==== test/iacd_exc_model.sv ====
// Exception unit model that counts software emulation requests.
`timescale 1ns/10ps

module iacd_exc_model (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Request from the block.
  input wire logic emu_exc,
  // Number of cycles the request was seen high.
  output logic [31:0] taken_ff
);
  // handler entry count
  // Every high cycle counts, so a stretched pulse shows as extra entries.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      taken_ff <= 32'h0;
    end else if (emu_exc) begin
      taken_ff <= taken_ff + 32'h1;
    end
  end
endmodule : iacd_exc_model

// ==== test/iacd_core_bench.sv ====
// Self-checking bench for the class decoder and add/subtract unit.
`timescale 1ns/10ps

module iacd_core_bench
  import iacd_pkg::*;
;
  typedef struct {
    logic [31:0] d;
    logic [31:0] m;
    logic e;
    string n;
  } iacd_note_type;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, emu_exc;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, taken, rng, exp_res, exp_ier, exp_traps, v;
  logic [3:0] exp_cond;
  int num_errors = 0;
  int tests_run = 0;
  iacd_note_type notes[$];
  iacd_note_type cur;
  logic [8:0] xos[10] = '{XO_ADD, XO_ADDC, XO_SUBF, XO_SUBFC, XO_ADDE,
    XO_SUBFE, XO_ADDME, XO_SUBFME, XO_ADDZE, XO_SUBFZE};
  logic [31:0] bad_ins[9] = '{32'h0, {OP_ROT64, 26'h0}, 32'h7C00_0002,
    {6'h01, 26'h0}, {OP_RSVD, 26'h0}, {OP_EXT31, 16'h0C22, XO_ADDZE, 1'h0},
    32'h4C00_012C, 32'h4FE0_012C, 32'h4400_0002};
  logic [31:0] bad_st[9] = '{32'h5, 32'h5, 32'h5, 32'h5, 32'h7, 32'h4,
    32'h10, 32'h10, 32'h10};

  // Clock of 40 ns period.
  initial begin
    pclk = 1'h0;
    forever #20 pclk = ~pclk;
  end

  iacd_core uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .emu_exc(emu_exc));
  iacd_exc_model exc (.pclk(pclk), .presetn(presetn), .emu_exc(emu_exc),
    .taken_ff(taken));

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  // Xorshift generator for operands and encodings.
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : rnd

  // Register form; the minus-one and zero forms need an empty second field.
  function automatic logic [31:0] enc(logic [8:0] xo, logic oe, logic rec);
    return {OP_EXT31, 10'h61, xo[6] ? 5'h0 : 5'h2, oe, xo, rec};
  endfunction : enc

  task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  // One APB transfer; the expected answer is noted before it starts.
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d,
      logic [31:0] ed, logic [31:0] m, logic e, string n);
    notes.push_back('{ed, m, e, n});
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : xfer

  task automatic wr(logic [7:0] a, logic [31:0] d);
    xfer(1'h1, a, d, 32'h0, 32'h0, 1'h0, "write");
  endtask : wr

  task automatic rd(logic [7:0] a, logic [31:0] ed, string n);
    xfer(1'h0, a, 32'h0, ed, 32'hFFFF_FFFF, 1'h0, n);
  endtask : rd

  // Loads operands, executes one word, then reads back result, flags, condition field and status.
  task automatic run_op(logic [31:0] ins, a, b, xv, st);
    logic [32:0] s;
    logic [31:0] x, y, imm;
    logic c, wca, oe, rec, ov;
    logic [8:0] xo;
    xo = ins[9:1];
    imm = {{16{ins[15]}}, ins[15:0]};
    oe = ins[OE_BIT];
    rec = ins[REC_BIT];
    // operand selection
    // Subtract forms have xo bit 1 clear; extended forms have xo bit 7 set.
    x = ins[2] ? a : ~a;
    c = xo[7] ? xv[XER_CA_BIT] : !ins[2];
    y = xo[6] ? {32{xo[5]}} : b;
    wca = !(xo == XO_ADD || xo == XO_SUBF);
    // Negate adds nothing from the second field and keeps the carry.
    if (xo == XO_NEG) begin
      y = 32'h0;
      wca = 1'h0;
    end
    if (ins[31:26] != OP_EXT31) begin
      x = ins[31:26] == OP_SUBFIC ? ~a : a;
      c = ins[31:26] == OP_SUBFIC;
      y = imm;
      oe = 1'h0;
      rec = ins[31:26] == OP_ADDIC_REC;
      wca = ins[31:26] != OP_ADDI;
    end
    exp_ier = xv;
    wr(OFF_SRC_A, a);
    wr(OFF_SRC_B, b);
    wr(OFF_XER, xv);
    wr(OFF_INSTR, ins);
    if (st[STAT_EXEC_BIT]) begin
      s = {1'h0, x} + {1'h0, y} + {32'h0, c};
      exp_res = s[31:0];
      ov = (x[31] == y[31]) && (s[31] != x[31]);
      if (wca) exp_ier[XER_CA_BIT] = s[32];
      if (oe) exp_ier[XER_OV_BIT] = ov;
      if (oe) exp_ier[XER_SO_BIT] = xv[XER_SO_BIT] | ov;
      if (rec) exp_cond = {s[31], !s[31] && s[31:0] != 32'h0,
        s[31:0] == 32'h0, exp_ier[XER_SO_BIT]};
    end
    exp_traps += {31'h0, st[STAT_EMU_BIT]};
    rd(OFF_RESULT, exp_res, "result");
    rd(OFF_XER, exp_ier, "int_exception_reg");
    rd(OFF_COND, {28'h0, exp_cond}, "result_cond_field");
    rd(OFF_STATUS, st, "status");
    check("trap count", taken, exp_traps);
  endtask : run_op

  // Monitor takes the oldest note at every completed transfer.
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      cur = notes.pop_front();
      check({cur.n, " data"}, prdata & cur.m, cur.d & cur.m);
      check({cur.n, " error"}, {31'h0, pslverr}, {31'h0, cur.e});
    end
  end

  // Watchdog against a hung handshake.
  initial begin
    repeat (30000) @(posedge pclk);
    num_errors++;
    wrap_up();
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    {exp_res, exp_ier, exp_traps, exp_cond} = '0;
    rng = 32'hDA8E;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      rd(8'(i * 4), i == 7 ? EMU_VECTOR : 32'h0, "reset value");
    end
    xfer(1'h0, 8'h20, 32'h0, 32'h0, 32'hFFFF_FFFF, 1'h1, "unmapped");
    xfer(1'h0, 8'h02, 32'h0, 32'h0, 32'hFFFF_FFFF, 1'h1, "misaligned");
    xfer(1'h1, 8'h24, 32'h1, 32'h0, 32'h0, 1'h1, "unmapped write");
    run_op(enc(XO_ADD, 1'h1, 1'h1), 32'h7FFF_FFFF, 32'h1, 32'h0, 32'h8);
    run_op(enc(XO_ADD, 1'h1, 1'h0), 32'h1, 32'h1, 32'h8000_0000, 32'h8);
    run_op(enc(XO_ADDC, 1'h0, 1'h1), 32'hFFFF_FFFF, 32'h1, 32'h0, 32'h8);
    run_op(enc(XO_SUBFC, 1'h1, 1'h1), 32'h5, 32'h5, 32'h0, 32'h8);
    run_op(enc(XO_SUBF, 1'h0, 1'h1), 32'h6, 32'h5, 32'h0, 32'h8);
    run_op({OP_ADDIC_REC, 10'h61, 16'h8000}, 32'h0, 32'h0, 32'h0, 32'h8);
    run_op({OP_ADDIC, 10'h61, 16'h0001}, 32'hFFFF_FFFF, 32'h0, 32'h0, 32'h8);
    run_op({OP_SUBFIC, 10'h61, 16'hFFFF}, 32'h1, 32'h0, 32'h0, 32'h8);
    run_op(enc(XO_NEG, 1'h1, 1'h1), 32'h8000_0000, 32'h0, 32'h0,
      32'h8);
    run_op({OP_ADDI, 10'h61, 16'hFFFE}, 32'h5, 32'h0, 32'h2000_0000,
      32'h8);
    wr(OFF_RESULT, 32'hDEAD_BEEF);
    wr(OFF_VECTOR, 32'h0);
    rd(OFF_RESULT, exp_res, "read-only result");
    rd(OFF_VECTOR, EMU_VECTOR, "vector");
    for (int i = 0; i < 40; i++) begin
      v = rnd();
      run_op(enc(xos[v % 10], v[4], v[5]), rnd(), rnd(), {v[31:29], 29'h0},
        32'h8);
    end
    for (int i = 0; i < 9; i++) begin
      v = rnd();
      run_op(bad_ins[i], v, ~v, {v[31:29], 29'h0}, bad_st[i]);
    end
    wrap_up();
  end
endmodule : iacd_core_bench
